// *** common/depl_pkg.sv ***
// Constants, field layouts and carrier types for the dual-edge probe latch.
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz core clock.
package depl_pkg;
   // -------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------
   localparam int DEF_DATA_W    = 8;
   localparam int DEF_FIRST_CH  = 6;
   localparam int DEF_SECOND_CH = 7;
   localparam int DEF_DLY_DEPTH = 16;
   localparam int DEL_W         = 4;
   localparam int ADDR_W        = 5;
   localparam int TEMP_W        = 8;
   // -------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CTRL_OFS     = 5'h00;
   localparam logic [ADDR_W-1:0] STATUS_OFS   = 5'h04;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 5'h08;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 5'h0C;
   localparam logic [ADDR_W-1:0] DELAY_OFS    = 5'h10;
   localparam logic [ADDR_W-1:0] TEMP_LIM_OFS = 5'h14;
   localparam logic [ADDR_W-1:0] DATA_OFS     = 5'h18;
   // -------------------------------------------------------------
   // Field positions and reset values
   // -------------------------------------------------------------
   localparam int CTRL_W        = 6;
   localparam int IRQ_W         = 3;
   localparam int DLY_SECOND_POS = 8;
   localparam int STAT_TEMP_POS = 8;
   localparam logic [TEMP_W-1:0] TEMP_LIM_RST = 8'hC8;
   localparam logic [1:0]        RESP_OKAY    = 2'h0;
   localparam logic [1:0]        RESP_SLVERR  = 2'h2;
   // -------------------------------------------------------------
   // Types
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      MIX_PASS = 2'b00,
      MIX_AND  = 2'b01,
      MIX_OR   = 2'b10,
      MIX_XOR  = 2'b11
   } depl_mix_t;
   typedef struct packed {
      depl_mix_t mix;
      logic      rsv;
      logic      single;
      logic      full;
      logic      run;
   } depl_ctrl_t;
   typedef struct packed {
      logic hot;
      logic ext_event;
      logic load;
   } depl_irq_t;
   typedef struct packed {
      logic [DEL_W-1:0] second;
      logic [DEL_W-1:0] first;
   } depl_delay_t;
endpackage : depl_pkg

// *** core/depl_delay.sv ***
// Per-channel adjustable delay in whole core-clock cycles.
// Assumes sel is held steady while the channel is in use.
`timescale 1ns/1ps
module depl_delay
   import depl_pkg::*;
#(
   parameter int DEPTH = DEF_DLY_DEPTH,
   parameter int SEL_W = $clog2(DEPTH)
)
(
   input  wire logic             clk,   // Core clock
   input  wire logic             rst,   // Synchronous reset
   input  wire logic             din,   // Channel bit
   input  wire logic [SEL_W-1:0] sel,   // Delay in cycles
   output logic                  dout   // Delayed bit, one extra cycle
);
   logic [DEPTH-2:0] sh;
   logic [DEPTH-2:0] next_sh;
   logic [DEPTH-1:0] taps;
   logic             next_dout;
   assign taps = {sh, din};
   always_comb
   begin
      next_sh   = {sh[DEPTH-3:0], din};
      next_dout = taps[sel];
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sh   <= '0;
         dout <= 1'b0;
      end
      else
      begin
         sh   <= next_sh;
         dout <= next_dout;
      end
   end
   property p_dly_zero;
      @(posedge clk) disable iff (rst)
      ($past(sel) == 0) |-> (dout == $past(din));
   endproperty
   a_dly_zero: assert property (p_dly_zero) else $error("zero delay tap wrong");
   property p_dly_two;
      @(posedge clk) disable iff (rst)
      ($past(sel) == 2) ##0 !$past(rst, 3) |-> (dout == $past(din, 3));
   endproperty
   a_dly_two: assert property (p_dly_two) else $error("two cycle tap wrong");
endmodule : depl_delay

// *** core/depl_sync.sv ***
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent level from outside the core clock.
`timescale 1ns/1ps
module depl_sync
#(
   parameter int W = 1
)
(
   input  wire logic         clk,   // Core clock
   input  wire logic         rst,   // Synchronous reset
   input  wire logic [W-1:0] din,   // Asynchronous levels
   output logic      [W-1:0] dout   // Synchronised levels
);
   logic [W-1:0] meta;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta <= '0;
         dout <= '0;
      end
      else
      begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : depl_sync

// *** core/depl_top.sv ***
// Probe-side latch: double-edge capture of cable data, simultaneous
// output word, two delayable mixable channels, event return, overheat.
// Assumes cable clock and data change together, well below CORE_CLK/4.
// Function
// - Rising forwarded-clock edge captures cable data into the rising bank.
// - Falling edge captures cable data into the falling bank (double-edge).
// - Half channel mode uses only the rising bank.
// - Output stage updates all channels together, except the two delayed mixable channels in single-edge mode.
// - External event input is passed back to the pattern board.
// - Temperature is monitored and overheat reported to the processor.
// - Single-edge (variable) probe captures on rising edge only, no falling bank.
// - Each mixable channel gets its own adjustable delay before output.
// - The two mixable channels combine through a selectable logic function.
`timescale 1ns/1ps
module depl_top
   import depl_pkg::*;
#(
   parameter int DATA_W    = DEF_DATA_W,
   parameter int FIRST_CH  = DEF_FIRST_CH,
   parameter int SECOND_CH = DEF_SECOND_CH,
   parameter int DLY_DEPTH = DEF_DLY_DEPTH
)
(
   input  wire logic                CORE_CLK,   // 10 MHz core clock
   input  wire logic                RST,        // Sync reset, high
   input  wire logic [ADDR_W-1:0]   AWADDR,     // AXI write address
   input  wire logic                AWVALID,    // AXI
   output logic                     AWREADY,    // AXI
   input  wire logic [31:0]         WDATA,      // AXI write data
   input  wire logic [3:0]          WSTRB,      // AXI byte enables
   input  wire logic                WVALID,     // AXI
   output logic                     WREADY,     // AXI
   output logic [1:0]               BRESP,      // AXI
   output logic                     BVALID,     // AXI
   input  wire logic                BREADY,     // AXI
   input  wire logic [ADDR_W-1:0]   ARADDR,     // AXI read address
   input  wire logic                ARVALID,    // AXI
   output logic                     ARREADY,    // AXI
   output logic [31:0]              RDATA,      // AXI read data
   output logic [1:0]               RRESP,      // AXI
   output logic                     RVALID,     // AXI
   input  wire logic                RREADY,     // AXI
   input  wire logic                LINK_CLK,   // Forwarded cable clock
   input  wire logic [DATA_W-1:0]   LINK_DATA,  // Cable channel data
   input  wire logic                EVENT_IN,   // Connector event pin
   output logic                     EVENT_OUT,  // Event to pattern board
   input  wire logic [TEMP_W-1:0]   TEMP_CODE,  // Sensor code, core clock
   output logic                     OVERHEAT,   // Overheat level
   output logic [2*DATA_W-1:0]      DATA_OUT,   // Output word
   output logic                     DATA_LOAD,  // New word pulse
   output logic                     IRQ         // Interrupt level
);
   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic              clk_s;
   logic              event_s;
   logic [DATA_W-1:0] data_s;
   // Clock and data share one latency so edges pick matching data
   depl_sync #(
      .W (DATA_W + 2)
   ) u_sync (
      .clk  (CORE_CLK),
      .rst  (RST),
      .din  ({EVENT_IN, LINK_CLK, LINK_DATA}),
      .dout ({event_s, clk_s, data_s})
   );
   // -------------------------------------------------------------
   // Registers and link state
   // -------------------------------------------------------------
   depl_ctrl_t          ctrl, next_ctrl;
   depl_irq_t           irq_stat, next_irq_stat;
   depl_irq_t           irq_mask, next_irq_mask;
   depl_delay_t         dly, next_dly;
   logic [TEMP_W-1:0]   temp_lim, next_temp_lim;
   logic                aw_got, next_aw_got;
   logic                w_got, next_w_got;
   logic [ADDR_W-1:0]   waddr, next_waddr;
   logic [31:0]         wdata, next_wdata;
   logic [3:0]          wstrb, next_wstrb;
   logic                bvalid, next_bvalid;
   logic [1:0]          bresp, next_bresp;
   logic                rvalid, next_rvalid;
   logic [31:0]         rdata, next_rdata;
   logic [1:0]          rresp, next_rresp;
   logic                irq, next_irq;
   logic                wr_ctrl;
   logic                clk_d, next_clk_d;
   logic                event_d, next_event_d;
   logic [DATA_W-1:0]   bank_a, next_bank_a;
   logic [DATA_W-1:0]   bank_b, next_bank_b;
   logic [2*DATA_W-1:0] out_word, next_out_word;
   logic [2*DATA_W-1:0] data_out, next_data_out;
   logic                load_q, next_load;
   logic                data_load, next_data_load;
   logic                overheat, next_overheat;
   depl_irq_t           ev, next_ev;
   logic                rise, fall, two_edge;
   logic [1:0]          dly_out;
   assign rise     = clk_s & ~clk_d;
   assign fall     = ~clk_s & clk_d;
   assign two_edge = ctrl.full & ~ctrl.single;
   // -------------------------------------------------------------
   // Mixable channel delays
   // -------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_dly
         depl_delay #(
            .DEPTH (DLY_DEPTH)
         ) u_dly (
            .clk  (CORE_CLK),
            .rst  (RST),
            .din  (out_word[g == 0 ? FIRST_CH : SECOND_CH]),
            .sel  (g == 0 ? dly.first : dly.second),
            .dout (dly_out[g])
         );
      end
   endgenerate
   function automatic logic mix_fn(input depl_mix_t f, input logic a, input logic b);
      case (f)
         MIX_AND: mix_fn = a & b;
         MIX_OR:  mix_fn = a | b;
         MIX_XOR: mix_fn = a ^ b;
         default: mix_fn = a;
      endcase
   endfunction : mix_fn
   // -------------------------------------------------------------
   // Link capture and output stage
   // -------------------------------------------------------------
   always_comb
   begin
      next_clk_d    = clk_s;
      next_event_d  = event_s;
      next_bank_a   = bank_a;
      next_bank_b   = bank_b;
      next_out_word = out_word;
      next_load     = 1'b0;
      if (ctrl.run && rise)
      begin
         next_bank_a = data_s;
         if (!two_edge)
         begin
            next_out_word = {{DATA_W{1'b0}}, data_s};
            next_load     = 1'b1;
         end
      end
      if (ctrl.run && fall && two_edge)
      begin
         next_bank_b   = data_s;
         next_out_word = {data_s, bank_a};
         next_load     = 1'b1;
      end
      next_data_out = out_word;
      if (ctrl.single)
      begin
         next_data_out[FIRST_CH]  = mix_fn(ctrl.mix, dly_out[0], dly_out[1]);
         next_data_out[SECOND_CH] = dly_out[1];
      end
      next_data_load   = load_q;
      next_overheat    = (TEMP_CODE >= temp_lim);
      next_ev.load      = next_load;
      next_ev.ext_event = event_s & ~event_d;
      next_ev.hot       = next_overheat & ~overheat;
   end
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         clk_d     <= 1'b0;
         event_d   <= 1'b0;
         bank_a    <= '0;
         bank_b    <= '0;
         out_word  <= '0;
         data_out  <= '0;
         load_q    <= 1'b0;
         data_load <= 1'b0;
         overheat  <= 1'b0;
         ev        <= '0;
      end
      else
      begin
         clk_d     <= next_clk_d;
         event_d   <= next_event_d;
         bank_a    <= next_bank_a;
         bank_b    <= next_bank_b;
         out_word  <= next_out_word;
         data_out  <= next_data_out;
         load_q    <= next_load;
         data_load <= next_data_load;
         overheat  <= next_overheat;
         ev        <= next_ev;
      end
   end
   assign EVENT_OUT = event_d;
   assign OVERHEAT  = overheat;
   assign DATA_OUT  = data_out;
   assign DATA_LOAD = data_load;
   // -------------------------------------------------------------
   // AXI4-Lite slave and register file
   // -------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++)
      begin
         m[8*i +: 8] = {8{be[i]}};
      end
      merge = (old & ~m) | (d & m);
   endfunction : merge
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      is_mapped = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == IRQ_STAT_OFS) ||
                  (a == IRQ_MASK_OFS) || (a == DELAY_OFS) || (a == TEMP_LIM_OFS) ||
                  (a == DATA_OFS);
   endfunction : is_mapped
   assign AWREADY = ~aw_got & ~bvalid;
   assign WREADY  = ~w_got & ~bvalid;
   assign ARREADY = ~rvalid;
   always_comb
   begin
      logic [31:0] tmp;
      logic [31:0] clr;
      tmp           = '0;
      clr           = '0;
      wr_ctrl       = 1'b0;
      next_aw_got   = aw_got;
      next_w_got    = w_got;
      next_waddr    = waddr;
      next_wdata    = wdata;
      next_wstrb    = wstrb;
      next_bvalid   = bvalid;
      next_bresp    = bresp;
      next_rvalid   = rvalid;
      next_rdata    = rdata;
      next_rresp    = rresp;
      next_ctrl     = ctrl;
      next_irq_mask = irq_mask;
      next_dly      = dly;
      next_temp_lim = temp_lim;
      if (AWVALID && AWREADY)
      begin
         next_aw_got = 1'b1;
         next_waddr  = AWADDR;
      end
      if (WVALID && WREADY)
      begin
         next_w_got = 1'b1;
         next_wdata = WDATA;
         next_wstrb = WSTRB;
      end
      if (aw_got && w_got)
      begin
         next_aw_got = 1'b0;
         next_w_got  = 1'b0;
         next_bvalid = 1'b1;
         next_bresp  = is_mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
         if (waddr == CTRL_OFS)
         begin
            wr_ctrl       = 1'b1;
            tmp           = merge(32'(ctrl), wdata, wstrb);
            next_ctrl     = depl_ctrl_t'(tmp[CTRL_W-1:0]);
            next_ctrl.rsv = 1'b0;
            // Changing the mix mid-pattern would glitch the mixed channel
            if (ctrl.run)
            begin
               next_ctrl.mix = ctrl.mix;
            end
         end
         else if (waddr == IRQ_STAT_OFS)
         begin
            clr = merge(32'h0000_0000, wdata, wstrb);
         end
         else if (waddr == IRQ_MASK_OFS)
         begin
            tmp           = merge(32'(irq_mask), wdata, wstrb);
            next_irq_mask = depl_irq_t'(tmp[IRQ_W-1:0]);
         end
         else if (waddr == DELAY_OFS)
         begin
            tmp         = merge(32'({dly.second, {(DLY_SECOND_POS-DEL_W){1'b0}}, dly.first}), wdata, wstrb);
            next_dly    = {tmp[DLY_SECOND_POS +: DEL_W], tmp[DEL_W-1:0]};
         end
         else if (waddr == TEMP_LIM_OFS)
         begin
            tmp           = merge(32'(temp_lim), wdata, wstrb);
            next_temp_lim = tmp[TEMP_W-1:0];
         end
      end
      else if (bvalid && BREADY)
      begin
         next_bvalid = 1'b0;
      end
      // Hardware set wins over a same-cycle clear
      next_irq_stat = (irq_stat & ~depl_irq_t'(clr[IRQ_W-1:0])) | ev;
      next_irq      = |(next_irq_stat & next_irq_mask);
      if (ARVALID && ARREADY)
      begin
         next_rvalid = 1'b1;
         next_rresp  = is_mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
         if (ARADDR == CTRL_OFS)
         begin
            next_rdata = 32'(ctrl);
         end
         else if (ARADDR == STATUS_OFS)
         begin
            next_rdata = 32'({TEMP_CODE, {(STAT_TEMP_POS-3){1'b0}}, event_d, clk_s, overheat});
         end
         else if (ARADDR == IRQ_STAT_OFS)
         begin
            next_rdata = 32'(irq_stat);
         end
         else if (ARADDR == IRQ_MASK_OFS)
         begin
            next_rdata = 32'(irq_mask);
         end
         else if (ARADDR == DELAY_OFS)
         begin
            next_rdata = 32'({dly.second, {(DLY_SECOND_POS-DEL_W){1'b0}}, dly.first});
         end
         else if (ARADDR == TEMP_LIM_OFS)
         begin
            next_rdata = 32'(temp_lim);
         end
         else if (ARADDR == DATA_OFS)
         begin
            next_rdata = 32'(data_out);
         end
         else
         begin
            next_rdata = '0;
         end
      end
      else if (rvalid && RREADY)
      begin
         next_rvalid = 1'b0;
      end
   end
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         aw_got   <= 1'b0;
         w_got    <= 1'b0;
         waddr    <= '0;
         wdata    <= '0;
         wstrb    <= '0;
         bvalid   <= 1'b0;
         bresp    <= RESP_OKAY;
         rvalid   <= 1'b0;
         rdata    <= '0;
         rresp    <= RESP_OKAY;
         ctrl     <= '0;
         irq_stat <= '0;
         irq_mask <= '0;
         dly      <= '0;
         temp_lim <= TEMP_LIM_RST;
         irq      <= 1'b0;
      end
      else
      begin
         aw_got   <= next_aw_got;
         w_got    <= next_w_got;
         waddr    <= next_waddr;
         wdata    <= next_wdata;
         wstrb    <= next_wstrb;
         bvalid   <= next_bvalid;
         bresp    <= next_bresp;
         rvalid   <= next_rvalid;
         rdata    <= next_rdata;
         rresp    <= next_rresp;
         ctrl     <= next_ctrl;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         dly      <= next_dly;
         temp_lim <= next_temp_lim;
         irq      <= next_irq;
      end
   end
   assign BVALID = bvalid;
   assign BRESP  = bresp;
   assign RVALID = rvalid;
   assign RDATA  = rdata;
   assign RRESP  = rresp;
   assign IRQ    = irq;
   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   property p_rise_bank;
      @(posedge CORE_CLK) disable iff (RST)
      (ctrl.run && rise) |=> (bank_a == $past(data_s));
   endproperty
   a_rise_bank: assert property (p_rise_bank) else $error("rising bank missed");
   property p_fall_bank;
      @(posedge CORE_CLK) disable iff (RST)
      (ctrl.run && fall && two_edge) |=> (bank_b == $past(data_s)) && load_q;
   endproperty
   a_fall_bank: assert property (p_fall_bank) else $error("falling bank missed");
   property p_half_mode;
      @(posedge CORE_CLK) disable iff (RST)
      (!ctrl.full && !$past(ctrl.full)) |-> $stable(bank_b);
   endproperty
   a_half_mode: assert property (p_half_mode) else $error("falling bank used in half mode");
   property p_together;
      @(posedge CORE_CLK) disable iff (RST)
      (!ctrl.single && !$past(ctrl.single) && !$past(ctrl.single, 2) && (DATA_OUT != $past(DATA_OUT))) |-> DATA_LOAD;
   endproperty
   a_together: assert property (p_together) else $error("output changed without load");
   property p_event_pass;
      @(posedge CORE_CLK) disable iff (RST)
      $rose(event_s) |=> EVENT_OUT ##1 irq_stat.ext_event;
   endproperty
   a_event_pass: assert property (p_event_pass) else $error("event not returned");
   property p_overheat;
      @(posedge CORE_CLK) disable iff (RST)
      (TEMP_CODE >= temp_lim) ##1 !$past(OVERHEAT) |-> OVERHEAT ##1 irq_stat.hot;
   endproperty
   a_overheat: assert property (p_overheat) else $error("overheat not reported");
   property p_single_edge;
      @(posedge CORE_CLK) disable iff (RST)
      (ctrl.single && ctrl.run && rise) |=> load_q && (out_word[2*DATA_W-1:DATA_W] == '0);
   endproperty
   a_single_edge: assert property (p_single_edge) else $error("single edge capture wrong");
   property p_mix_and;
      @(posedge CORE_CLK) disable iff (RST)
      (ctrl.single && ctrl.mix == MIX_AND) |=> (DATA_OUT[FIRST_CH] == $past(dly_out[0] & dly_out[1]));
   endproperty
   a_mix_and: assert property (p_mix_and) else $error("mix function wrong");
   property p_both_banks;
      @(posedge CORE_CLK) disable iff (RST)
      (ctrl.run && fall && two_edge) |=> (out_word == {$past(data_s), $past(bank_a)}) ##1 DATA_LOAD;
   endproperty
   a_both_banks: assert property (p_both_banks) else $error("banks not loaded together");
   property p_mix_held;
      @(posedge CORE_CLK) disable iff (RST)
      (wr_ctrl && ctrl.run) |=> (ctrl.mix == $past(ctrl.mix));
   endproperty
   a_mix_held: assert property (p_mix_held) else $error("mix changed while running");
endmodule : depl_top

// *** verification/depl_link_drv.sv ***
// Cable-side model: forwarded clock and channel data from the pattern board.
// Assumes the bench calls frame() and waits for it to return.
`timescale 1ns/1ps
module depl_link_drv
(
   input  wire logic  CORE_CLK,    // Core clock, paces the cable
   output logic       LINK_CLK,    // Forwarded clock
   output logic [7:0] LINK_DATA    // Channel data
);
   initial
   begin
      LINK_CLK  = 1'b0;
      LINK_DATA = 8'h00;
   end
   // Clock stands low between frames; data settles two core cycles around each edge
   task automatic frame(input logic [7:0] rise_w, input logic [7:0] fall_w);
      LINK_DATA <= rise_w;
      repeat (2) @(posedge CORE_CLK);
      LINK_CLK <= 1'b1;
      repeat (2) @(posedge CORE_CLK);
      LINK_DATA <= fall_w;
      repeat (2) @(posedge CORE_CLK);
      LINK_CLK <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      LINK_DATA <= ~fall_w;
   endtask : frame
endmodule : depl_link_drv

// *** verification/tb.sv ***
// Self-checking bench for the probe latch: register bus, capture, mix, events.
// Assumes the cable model sits in depl_link_drv.
`timescale 1ns/1ps
module tb;
   import depl_pkg::*;
   logic CORE_CLK = 1'b0, RST = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
   logic ARVALID = 1'b0, RREADY = 1'b0, EVENT_IN = 1'b0, f;
   logic [ADDR_W-1:0] AWADDR = '0, ARADDR = '0;
   logic [31:0]       WDATA = '0, d, rnd = 32'h5EFDD3B0;
   logic [TEMP_W-1:0] TEMP_CODE = 8'h10;
   logic [1:0]        r, wresp, BRESP, RRESP;
   logic [15:0]       msk = 16'hFFFF, DATA_OUT, exp_q[$];
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, LINK_CLK, EVENT_OUT, OVERHEAT, DATA_LOAD, IRQ;
   logic [31:0] RDATA;
   logic [7:0]  LINK_DATA;
   int n_errors = 0, num_checks = 0;

   depl_top u_depl_top (.CORE_CLK(CORE_CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .LINK_CLK(LINK_CLK), .LINK_DATA(LINK_DATA), .EVENT_IN(EVENT_IN), .EVENT_OUT(EVENT_OUT),
      .TEMP_CODE(TEMP_CODE), .OVERHEAT(OVERHEAT), .DATA_OUT(DATA_OUT), .DATA_LOAD(DATA_LOAD), .IRQ(IRQ));
   depl_link_drv u_depl_link_drv (.CORE_CLK(CORE_CLK), .LINK_CLK(LINK_CLK), .LINK_DATA(LINK_DATA));

   always #50 CORE_CLK = ~CORE_CLK;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Handshakes judged at the rising edge; one idle edge keeps back-to-back calls apart
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
      logic aw, w, b;
      AWADDR <= a; WDATA <= v; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1; b = 1'b0;
      while (!b)
      begin
         @(posedge CORE_CLK);
         aw = AWVALID && AWREADY; w = WVALID && WREADY; b = BVALID; wresp = BRESP;
         if (aw) AWVALID <= 1'b0;
         if (w) WVALID <= 1'b0;
         if (b) BREADY <= 1'b0;
      end
      @(posedge CORE_CLK);
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v, output logic [1:0] rr);
      logic ar, b;
      ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1; b = 1'b0;
      while (!b)
      begin
         @(posedge CORE_CLK);
         ar = ARVALID && ARREADY; b = RVALID; v = RDATA; rr = RRESP;
         if (ar) ARVALID <= 1'b0;
         if (b) RREADY <= 1'b0;
      end
      @(posedge CORE_CLK);
   endtask : rd

   task automatic print_verdict;
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // Unexpected loads meet an unknown note and fail
   always @(posedge CORE_CLK)
      if (!RST && DATA_LOAD === 1'b1)
         chk({18'h0, DATA_OUT & msk}, {18'h0, (exp_q.size() ? exp_q.pop_front() : 16'hXXXX) & msk});

   initial
   begin
      #3_000_000 n_errors++;
      print_verdict();
   end

   initial
   begin
      repeat (16) @(posedge CORE_CLK);
      RST <= 1'b0;
      @(posedge CORE_CLK);
      rd(TEMP_LIM_OFS, d, r);
      chk({r, d}, {RESP_OKAY, 24'h0, TEMP_LIM_RST});
      rd(5'h1C, d, r);
      chk({r, d}, {RESP_SLVERR, 32'h0});
      wr(5'h1C, 32'hFFFF_FFFF);
      chk({32'h0, wresp}, {32'h0, RESP_SLVERR});
      wr(DELAY_OFS, 32'h0000_0200);
      chk({32'h0, wresp}, {32'h0, RESP_OKAY});
      rd(DELAY_OFS, d, r);
      chk({r, d}, {RESP_OKAY, 32'h0000_0200});
      for (int i = 0; i < 4; i++)
      begin
         rnd = lfsr(rnd);
         wr(CTRL_OFS, {30'h0, ~i[0], 1'b1});
         exp_q.push_back(i[0] ? {8'h00, rnd[7:0]} : rnd[15:0]);
         u_depl_link_drv.frame(rnd[7:0], rnd[15:8]);
         repeat (8) @(posedge CORE_CLK);
      end
      msk = 16'hFF3F;
      for (int m = 0; m < 4; m++)
      begin
         rnd = lfsr(rnd);
         wr(CTRL_OFS, 32'h0);
         wr(CTRL_OFS, 32'h7 | (m << 4));
         wr(CTRL_OFS, 32'h7 | ((~m & 3) << 4));
         exp_q.push_back({8'h00, rnd[7:0]});
         u_depl_link_drv.frame(rnd[7:0], ~rnd[7:0]);
         repeat (30) @(posedge CORE_CLK);
         f = m == 0 ? rnd[6] : m == 1 ? rnd[6] & rnd[7] : m == 2 ? rnd[6] | rnd[7] : rnd[6] ^ rnd[7];
         chk({32'h0, DATA_OUT[7:6]}, {32'h0, rnd[7], f});
      end
      chk({2'h0, 32'(exp_q.size())}, 34'h0);
      chk({33'h0, IRQ}, 34'h0);
      EVENT_IN <= 1'b1;
      repeat (5) @(posedge CORE_CLK);
      chk({33'h0, EVENT_OUT}, 34'h1);
      wr(IRQ_MASK_OFS, 32'h2);
      repeat (2) @(posedge CORE_CLK);
      chk({33'h0, IRQ}, 34'h1);
      wr(IRQ_STAT_OFS, 32'h2);
      repeat (2) @(posedge CORE_CLK);
      chk({33'h0, IRQ}, 34'h0);
      TEMP_CODE <= TEMP_LIM_RST;
      repeat (3) @(posedge CORE_CLK);
      chk({33'h0, OVERHEAT}, 34'h1);
      TEMP_CODE <= TEMP_LIM_RST - 8'h01;
      repeat (3) @(posedge CORE_CLK);
      chk({33'h0, OVERHEAT}, 34'h0);
      print_verdict();
   end
endmodule : tb
